// ===== scl_pkg.sv
// Package with constants and carrier types for the serial configuration loader
package scl_pkg;

    // Flash commands
    localparam logic [7:0] CMD_WAKE       = 8'hab;
    localparam logic [7:0] CMD_FAST_READ  = 8'h0b;
    localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
    localparam logic [23:0] START_ADDR    = 24'h00_0000;
    localparam int          DUMMY_BITS    = 8;

    // Timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int RESET_LOW_NS   = 250;
    localparam int RESET_LOW_CYC  = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYC   = 2;

    // Reset values
    localparam logic SELECT_IDLE = 1'b1;

    typedef enum logic [5:0] {
        ST_WAIT   = 6'b000001,
        ST_WAKE   = 6'b000010,
        ST_GAP    = 6'b000100,
        ST_READ   = 6'b001000,
        ST_SLEEP  = 6'b010000,
        ST_DONE   = 6'b100000
    } scl_state_t;

    typedef enum logic [2:0] {
        MODE_NONE   = 3'b001,
        MODE_FLASH  = 3'b010,
        MODE_PERIPH = 3'b100
    } scl_mode_t;

    // Serial link pins toward the flash or processor
    typedef struct packed {
        logic selOut;
        logic selOe;
        logic sckOut;
        logic sckOe;
        logic dataOut;
        logic dataOe;
    } scl_pins_t;

    // Configuration byte handed to the fabric loader
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } scl_byte_t;

endpackage

// ===== scl_loader.sv
// Configuration start-up loader: mode choice, flash master read, peripheral receive
// Functional notes
// - Sample select pin after reset release
// - Select high, store programmed: use store
// - Select high, store blank: read flash
// - Select low: wait as serial peripheral
// - Select low, send 0x0B and address
// - Start address is always zero
// - Eight dummy clocks before data
// - Capture input bit on rising clock
// - Deselect flash after required bits
// - Optional power-down command 0xB9
// - Processor drives clock, select, data
// - Done output reports completion
// - Release serial pins when done
// - Hold global float during configuration
// - Hold global reset during configuration
module scl_loader #(
    parameter int BIT_COUNT_W = 20
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             configResetN,
    input  wire logic             storeProgrammed,
    input  wire logic [BIT_COUNT_W-1:0] imageBits,
    input  wire logic             powerDownEnable,
    input  wire logic             storeDone,
    input  wire logic             linkClk,
    input  wire logic             selIn,
    input  wire logic             sckIn,
    input  wire logic             dataIn,
    output scl_pkg::scl_pins_t    pins,
    output scl_pkg::scl_byte_t    cfgByte,
    output logic                  storeStart,
    output scl_pkg::scl_mode_t    mode,
    output logic                  configDoneOut,
    output logic                  globalFloatControl,
    output logic                  globalReset
);

    if (BIT_COUNT_W < 4 || BIT_COUNT_W > 32) begin
        $error("BIT_COUNT_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers (reset pin and select pin come from outside)
    logic [1:0] rstnSync;
    logic [1:0] selSync;
    logic       rstnPrev;
    logic [3:0] lowCount;
    logic       sampleNow;

    always_ff @(posedge clk) begin
        if (rst) begin
            rstnSync <= 2'b00;
            selSync  <= 2'b11;
        end else begin
            rstnSync <= {rstnSync[0], configResetN};
            selSync  <= {selSync[0], selIn};
        end
    end

    // Low-time counter: a release only counts after a long enough low phase
    always_ff @(posedge clk) begin
        if (rst) begin
            rstnPrev <= 1'b0;
            lowCount <= 4'h0;
        end else begin
            rstnPrev <= rstnSync[1];
            if (rstnSync[1]) begin
                lowCount <= 4'h0;
            end else if (lowCount < 4'(scl_pkg::RESET_LOW_CYC)) begin
                lowCount <= lowCount + 4'h1;
            end
        end
    end

    // Power-on reset release also triggers a sample, once the pin is high
    logic porPending;
    always_ff @(posedge clk) begin
        if (rst) begin
            porPending <= 1'b1;
        end else if (rstnSync[1]) begin
            porPending <= 1'b0;
        end
    end

    assign sampleNow = rstnSync[1] &&
        (porPending || (!rstnPrev && lowCount >= 4'(scl_pkg::RESET_LOW_CYC)));

    ////////////////////////////////////////////////////////////////////////////////
    // Mode choice
    scl_pkg::scl_state_t state;
    logic                busy;
    logic                linkDone;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= scl_pkg::MODE_NONE;
        end else if (sampleNow) begin
            if (!selSync[1]) begin
                mode <= scl_pkg::MODE_PERIPH;
            end else if (storeProgrammed) begin
                mode <= scl_pkg::MODE_NONE;
            end else begin
                mode <= scl_pkg::MODE_FLASH;
            end
        end
    end

    logic storeMode;
    always_ff @(posedge clk) begin
        if (rst) begin
            storeMode  <= 1'b0;
            storeStart <= 1'b0;
        end else begin
            storeStart <= sampleNow && selSync[1] && storeProgrammed;
            if (sampleNow) begin
                storeMode <= selSync[1] && storeProgrammed;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !rstnSync[1]) begin
            busy <= 1'b1;
        end else if (sampleNow) begin
            busy <= 1'b1;
        end else if ((storeMode && storeDone) || linkDone) begin
            busy <= 1'b0;
        end
    end

    assign configDoneOut      = !busy;
    assign globalFloatControl = busy;
    assign globalReset        = busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Flash master engine: serial clock is clk divided by two
    logic [31:0] shiftOut;
    logic [BIT_COUNT_W-1:0] bitCount;
    logic        sckReg;
    logic        selReg;
    logic        flashStart;
    logic        flashDone;
    logic [7:0]  rxShift;
    logic [2:0]  rxBits;
    scl_pkg::scl_byte_t masterByte;

    assign flashStart = sampleNow && selSync[1] && !storeProgrammed;

    always_ff @(posedge clk) begin
        if (rst || !rstnSync[1]) begin
            state      <= scl_pkg::ST_WAIT;
            sckReg     <= 1'b0;
            selReg     <= scl_pkg::SELECT_IDLE;
            shiftOut   <= 32'h0;
            bitCount   <= '0;
            flashDone  <= 1'b0;
        end else begin
            unique case (state)
                scl_pkg::ST_WAIT: begin
                    if (flashStart) begin
                        state    <= scl_pkg::ST_WAKE;
                        selReg   <= 1'b0;
                        shiftOut <= {scl_pkg::CMD_WAKE, 24'h0};
                        bitCount <= BIT_COUNT_W'(8);
                        flashDone <= 1'b0;
                    end
                end
                scl_pkg::ST_WAKE, scl_pkg::ST_SLEEP: begin
                    sckReg <= !sckReg;
                    if (sckReg) begin
                        shiftOut <= {shiftOut[30:0], 1'b0};
                        if (bitCount == BIT_COUNT_W'(1)) begin
                            selReg   <= 1'b1;
                            bitCount <= BIT_COUNT_W'(scl_pkg::DESELECT_CYC);
                            state    <= (state == scl_pkg::ST_WAKE) ? scl_pkg::ST_GAP
                                                                    : scl_pkg::ST_DONE;
                        end else begin
                            bitCount <= bitCount - BIT_COUNT_W'(1);
                        end
                    end
                end
                scl_pkg::ST_GAP: begin
                    if (bitCount == BIT_COUNT_W'(1)) begin
                        state    <= scl_pkg::ST_READ;
                        selReg   <= 1'b0;
                        shiftOut <= {scl_pkg::CMD_FAST_READ, scl_pkg::START_ADDR};
                        bitCount <= BIT_COUNT_W'(32 + scl_pkg::DUMMY_BITS) + imageBits;
                    end else begin
                        bitCount <= bitCount - BIT_COUNT_W'(1);
                    end
                end
                scl_pkg::ST_READ: begin
                    sckReg <= !sckReg;
                    if (sckReg) begin
                        shiftOut <= {shiftOut[30:0], 1'b0};
                        if (bitCount == BIT_COUNT_W'(1)) begin
                            selReg <= 1'b1;
                            if (powerDownEnable) begin
                                state    <= scl_pkg::ST_GAP;
                                bitCount <= BIT_COUNT_W'(scl_pkg::DESELECT_CYC);
                                shiftOut <= {scl_pkg::CMD_POWER_DOWN, 24'h0};
                            end else begin
                                state <= scl_pkg::ST_DONE;
                            end
                        end else begin
                            bitCount <= bitCount - BIT_COUNT_W'(1);
                        end
                    end
                end
                scl_pkg::ST_DONE: begin
                    flashDone <= 1'b1;
                    state     <= scl_pkg::ST_WAIT;
                end
                default: state <= scl_pkg::ST_WAIT;
            endcase
            // Power-down pass: gap leads into a one-byte selected transaction
            if (state == scl_pkg::ST_GAP && powerDownEnable && shiftOut[31:24] ==
                    scl_pkg::CMD_POWER_DOWN && bitCount == BIT_COUNT_W'(1)) begin
                state    <= scl_pkg::ST_SLEEP;
                selReg   <= 1'b0;
                shiftOut <= shiftOut;
                bitCount <= BIT_COUNT_W'(8);
            end
        end
    end

    // Data phase starts once command, address and dummy clocks are gone
    logic dataPhase;
    assign dataPhase = (state == scl_pkg::ST_READ) && (bitCount <= imageBits);

    // Capture on the rising serial clock edge: sckReg low now means rising next
    always_ff @(posedge clk) begin
        if (rst || state != scl_pkg::ST_READ) begin
            rxShift    <= 8'h00;
            rxBits     <= 3'h0;
            masterByte <= '0;
        end else begin
            masterByte.valid <= 1'b0;
            if (!sckReg && dataPhase) begin
                rxShift <= {rxShift[6:0], dataIn};
                rxBits  <= rxBits + 3'h1;
                if (rxBits == 3'h7) begin
                    masterByte.valid <= 1'b1;
                    masterByte.data  <= {rxShift[6:0], dataIn};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral receiver on the processor's own clock
    logic       linkRst1, linkRst2, linkClr;
    logic [7:0] perShift;
    logic [2:0] perBits;
    logic [15:0] perByte;
    logic       perToggle;
    logic [BIT_COUNT_W-1:0] perCount;
    logic       perFull;
    logic       periphActive;

    assign periphActive = (mode == scl_pkg::MODE_PERIPH) && busy;

    // Clear sets even with the link clock stopped; two link clocks release it before data
    always_ff @(posedge linkClk or posedge linkClr) begin
        if (linkClr) begin
            {linkRst2, linkRst1} <= 2'b11;
        end else begin
            {linkRst2, linkRst1} <= {linkRst1, 1'b0};
        end
    end

    always_ff @(posedge linkClk or posedge linkRst2) begin
        if (linkRst2) begin
            perShift  <= 8'h00;
            perBits   <= 3'h0;
            perByte   <= 16'h0000;
            perToggle <= 1'b0;
            perCount  <= '0;
            perFull   <= 1'b0;
        end else if (!selIn && !perFull) begin
            perShift <= {perShift[6:0], dataIn};
            perBits  <= perBits + 3'h1;
            perCount <= perCount + BIT_COUNT_W'(1);
            if (perCount + BIT_COUNT_W'(1) == imageBits) begin
                perFull <= 1'b1;
            end
            if (perBits == 3'h7) begin
                perByte[{perToggle, 3'h0} +: 8] <= {perShift[6:0], dataIn};
                perToggle <= !perToggle;
            end
        end
    end

    // Byte toggle and final level cross into clk; done trails the last byte by a cycle
    logic [2:0] togSync;
    logic [2:0] fullSync;
    scl_pkg::scl_byte_t perOut;
    always_ff @(posedge clk) begin
        if (rst) begin
            togSync  <= 3'b000;
            fullSync <= 3'b000;
            perOut   <= '0;
            linkClr  <= 1'b1;
        end else begin
            togSync  <= {togSync[1:0], perToggle};
            fullSync <= {fullSync[1:0], perFull};
            linkClr  <= !periphActive;
            perOut.valid <= (togSync[2] ^ togSync[1]) && busy;
            if (togSync[2] ^ togSync[1]) begin
                perOut.data <= perByte[{!togSync[1], 3'h0} +: 8];
            end
        end
    end

    assign linkDone = flashDone || (periphActive && fullSync[2]);
    assign cfgByte  = (mode == scl_pkg::MODE_PERIPH) ? perOut : masterByte;

    ////////////////////////////////////////////////////////////////////////////////
    // Pins: driven while busy in flash mode, also through a later reset until the next sample; released when done
    always_comb begin
        pins.selOut  = selReg;
        pins.sckOut  = sckReg;
        pins.dataOut = shiftOut[31];
        pins.selOe   = busy && mode == scl_pkg::MODE_FLASH;
        pins.sckOe   = pins.selOe;
        pins.dataOe  = pins.selOe;
    end

endmodule

// ===== scl_loader_properties.sv
// Port-level checks for the configuration loader
module scl_loader_checker (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          configResetN,
    input wire logic          storeStart,
    input scl_pkg::scl_pins_t pins,
    input scl_pkg::scl_mode_t mode,
    input wire logic          configDoneOut,
    input wire logic          globalFloatControl,
    input wire logic          globalReset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_float_busy: assert property (!configDoneOut |-> globalFloatControl)
        else $error("float released while busy");
    chk_reset_busy: assert property (!configDoneOut |-> globalReset)
        else $error("global reset released while busy");
    chk_done_release: assert property (configDoneOut |-> !pins.selOe && !pins.sckOe && !pins.dataOe)
        else $error("pins still driven after done");
    chk_done_clears: assert property ($rose(configDoneOut) |-> !globalFloatControl && !globalReset)
        else $error("done without releasing the fabric");
    chk_periph_quiet: assert property (mode == scl_pkg::MODE_PERIPH |-> !pins.selOe && !pins.dataOe)
        else $error("pins driven in peripheral mode");
    chk_store_start: assert property (storeStart |-> !pins.selOe ##1 !storeStart)
        else $error("store start not a lone pulse");
    chk_flash_owner: assert property ($rose(pins.selOe) |-> mode == scl_pkg::MODE_FLASH)
        else $error("select driven outside flash mode");
    // Outgoing bits may only move on the falling half of the serial clock
    chk_out_stable: assert property (!pins.selOut && pins.dataOe && $rose(pins.sckOut)
        |-> $stable(pins.dataOut))
        else $error("serial output moved on rising clock");
    chk_done_holds: assert property (configDoneOut && configResetN && $past(configResetN)
        && $past(configResetN, 2) && $past(configResetN, 3) |=> configDoneOut)
        else $error("done dropped without reset");
endmodule

bind scl_loader scl_loader_checker chk_u (.clk(clk), .rst(rst), .configResetN(configResetN),
    .storeStart(storeStart), .pins(pins), .mode(mode), .configDoneOut(configDoneOut),
    .globalFloatControl(globalFloatControl), .globalReset(globalReset));

// ===== scl_flash_model.sv
// Behavioural serial flash answering wake, fast read and power-down
module scl_flash_model (
    input wire logic sck,
    input wire logic selN,
    input wire logic si,
    output logic     so
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:15];
    logic [7:0]  op;
    logic [23:0] addr;
    logic        sleep;
    logic [7:0]  ops [$];
    int          cnt;
    initial begin
        so = 1'b1;
        sleep = 1'b0;
        op = 8'h00;
        cnt = 0;
    end
    always @(negedge selN) cnt = 0;
    always @(posedge sck) begin
        if (!selN) begin
            if (cnt < 8) op = {op[6:0], si};
            else if (cnt < 32) addr = {addr[22:0], si};
            cnt++;
            if (cnt == 8) ops.push_back(op);
            if (cnt == 8 && op == 8'hab) sleep = 1'b0;
        end
    end
    // Read data follows address and dummy byte, one bit per falling clock
    always @(negedge sck) begin
        if (!selN && op == 8'h0b && cnt >= 40) so <= mem[((cnt-40)/8)%16][7-((cnt-40)%8)];
    end
    // Released output floats to the pull-up level
    always @(posedge selN) begin
        so <= 1'b1;
        if (op == 8'hb9 && cnt == 8) sleep = 1'b1;
    end
endmodule

// ===== spi_config_loader_tb_top.sv
// Self-checking bench: flash master, on-chip store and peripheral start-up
module spi_config_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, rst, configResetN, storeProgrammed, powerDownEnable, storeDone;
    logic               linkClk, selDrv, periph, perData, flashSo, selIn, dataIn;
    logic               storeStart, configDoneOut, globalFloatControl, globalReset;
    scl_pkg::scl_pins_t pins;
    scl_pkg::scl_byte_t cfgByte;
    scl_pkg::scl_mode_t mode;
    logic [7:0]         expBytes [$];
    int                 failures, samplesChecked, starts;
    assign selIn = pins.selOe ? pins.selOut : selDrv;
    assign dataIn = periph ? perData : flashSo;
    scl_loader #(.BIT_COUNT_W(20)) dut_u (.clk(clk), .rst(rst), .configResetN(configResetN),
        .storeProgrammed(storeProgrammed), .imageBits(20'h00010),
        .powerDownEnable(powerDownEnable), .storeDone(storeDone), .linkClk(linkClk),
        .selIn(selIn), .sckIn(1'b0), .dataIn(dataIn), .pins(pins), .cfgByte(cfgByte),
        .storeStart(storeStart), .mode(mode), .configDoneOut(configDoneOut),
        .globalFloatControl(globalFloatControl), .globalReset(globalReset));
    scl_flash_model flash_u (.sck(pins.sckOe & pins.sckOut), .selN(pins.selOe ? pins.selOut : 1'b1),
        .si(pins.dataOut), .so(flashSo));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic ok, input string m);
        samplesChecked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task complete_run;
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Four cycles low clears the three-cycle minimum; partial frames are discarded
    task restart;
        tick(1);
        configResetN = 1'b0;
        tick(4);
        flash_u.ops.delete();
        configResetN = 1'b1;
    endtask
    task wait_done;
        for (int i = 0; i < 3000 && configDoneOut !== 1'b1; i++) tick(1);
    endtask
    always @(posedge clk) begin
        if (storeStart === 1'b1) starts++;
        if (cfgByte.valid === 1'b1) begin
            chk(expBytes.size() > 0 && cfgByte.data === expBytes[0], "config byte");
            if (expBytes.size() > 0) void'(expBytes.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task run_flash(input logic pde);
        for (int i = 0; i < 2; i++) begin
            flash_u.mem[i] = 8'($urandom);
            expBytes.push_back(flash_u.mem[i]);
        end
        storeProgrammed = 1'b0;
        selDrv = 1'b1;
        periph = 1'b0;
        powerDownEnable = pde;
        restart();
        wait_done();
        chk(configDoneOut === 1'b1, "flash load not done");
        chk(expBytes.size() == 0, "bytes missing");
        chk(flash_u.ops.size() == (pde ? 3 : 2), "command count");
        chk(flash_u.ops[0] === 8'hab, "wake command");
        chk(flash_u.ops[1] === 8'h0b, "read opcode");
        chk(flash_u.addr === 24'h000000, "start address");
        chk(!pde || flash_u.ops[2] === 8'hb9, "power-down opcode");
        chk(flash_u.sleep === pde, "flash sleep state");
    endtask
    task run_store;
        starts = 0;
        storeProgrammed = 1'b1;
        selDrv = 1'b1;
        periph = 1'b0;
        restart();
        tick(5 + ($urandom % 8));
        chk(configDoneOut === 1'b0, "done before store");
        storeDone = 1'b1;
        tick(1);
        storeDone = 1'b0;
        wait_done();
        chk(starts == 1 && configDoneOut === 1'b1, "store start or done");
        chk(flash_u.ops.size() == 0, "flash used in store mode");
    endtask
    // Link clock runs only while this task sends bits, selected or not; data moves on its falling edge
    task send_bits(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            perData = b[i];
            #16 linkClk = 1'b1;
            #16 linkClk = 1'b0;
        end
        perData = ~perData;
    endtask
    task run_periph;
        logic [7:0] b;
        storeProgrammed = 1'b0;
        selDrv = 1'b0;
        periph = 1'b1;
        restart();
        tick(4);
        #7;
        selDrv = 1'b1;
        send_bits(8'h5a);
        selDrv = 1'b0;
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            expBytes.push_back(b);
            send_bits(b);
        end
        wait_done();
        chk(configDoneOut === 1'b1 && expBytes.size() == 0, "peripheral load");
        chk(mode === scl_pkg::MODE_PERIPH, "peripheral mode");
    endtask
    initial begin
        rst = 1'b1;
        configResetN = 1'b0;
        storeProgrammed = 1'b0;
        powerDownEnable = 1'b0;
        storeDone = 1'b0;
        linkClk = 1'b0;
        selDrv = 1'b1;
        periph = 1'b0;
        perData = 1'b1;
        failures = 0;
        samplesChecked = 0;
        starts = 0;
        void'($urandom(32'hfb187109));
        tick(10);
        rst = 1'b0;
        tick(1);
        chk(globalFloatControl === 1'b1 && globalReset === 1'b1, "fabric not held");
        run_flash(1'b1);
        run_flash(1'b0);
        run_store();
        run_periph();
        complete_run();
    end
    initial begin
        #2000000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
